/* File: design/trig_defs.svh */
// trigger and breakpoint csr constants: csr numbers, fields, resets
// assumes the includer handles the csr number decode of the hart
`ifndef TRIG_DEFS_SVH
`define TRIG_DEFS_SVH

// csr numbers on the hart csr access path
`define CSR_TRIGGER_SELECT  12'h7A0
`define CSR_TRIGGER_FIRST   12'h7A1
`define CSR_TRIGGER_SECOND  12'h7A2
`define CSR_TRIGGER_THIRD   12'h7A3
`define CSR_DEBUG_CONTROL   12'h7B0
`define CSR_DEBUG_PC        12'h7B1
`define CSR_DEBUG_SCRATCH   12'h7B2

// match control field positions
`define MC_LOAD_BIT         0
`define MC_STORE_BIT        1
`define MC_FETCH_BIT        2
`define MC_USER_BIT         3
`define MC_MACHINE_BIT      6
`define MC_MATCH_LO         7
`define MC_MATCH_HI         10
`define MC_CHAIN_BIT        11
`define MC_ACTION_LO        12
`define MC_ACTION_HI        17
`define MC_TIMING_BIT       18
`define MC_SELECT_BIT       19
`define MC_MASKMAX_LO       21
`define MC_MASKMAX_HI       26
`define MC_DMODE_BIT        27
`define MC_TYPE_LO          28
`define MC_TYPE_HI          31

// type codes and fixed field values
`define TYPE_NONE           4'h0
`define TYPE_ADDR_MATCH     4'h2
`define MASKMAX_VALUE       6'h1F
`define MATCH_EXACT         4'h0
`define MATCH_NAPOT         4'h1
`define MATCH_GE            4'h2
`define MATCH_LT            4'h3
`define ACTION_EXCEPTION    6'h00
`define ACTION_DEBUG        6'h01

// reset values
`define SELECT_RESET        32'h0000_0000
`define CONTROL_RESET       32'h0000_0000

`endif

/* File: design/trig_pkg.sv */
// types shared by the trigger unit
// assumes trig_defs.svh supplies the numbers
`default_nettype none
package trig_pkg;
   typedef enum logic [1:0] {
      PRIV_USER       = 2'b00,
      PRIV_SUPERVISOR = 2'b01,
      PRIV_HYPERVISOR = 2'b10,
      PRIV_MACHINE    = 2'b11
   } priv_type;

   typedef enum logic [1:0] {
      ACC_LOAD  = 2'b00,
      ACC_STORE = 2'b01,
      ACC_FETCH = 2'b10,
      ACC_NONE  = 2'b11
   } access_type;

   typedef enum logic [1:0] {
      DBG_RUN   = 2'b00,
      DBG_HALT  = 2'b01
   } dbg_state_type;
endpackage
`default_nettype wire

/* File: design/addr_match.sv */
// one breakpoint address comparator: exact, napot, >= and <
// assumes control and address come from registers of the same clock
`include "trig_defs.svh"
`default_nettype none
module addr_match
   import trig_pkg::*;
#(
   parameter int XLEN = 32
) (
   input  wire logic [3:0]      kind_in,    // match kind field
   input  wire logic [XLEN-1:0] ref_in,     // match address register
   input  wire logic [XLEN-1:0] addr_in,    // access address
   output logic                 hit_out     // comparison true
);
   logic [XLEN-1:0] mask;

   // the lowest zero of ref and the ones below it give the napot don't-care bits
   always_comb begin
      mask    = ~(ref_in ^ (ref_in + XLEN'(1)));
      mask    = mask | {{(XLEN-1){1'b0}}, 1'b0};
      case (kind_in)
         `MATCH_EXACT: hit_out = (addr_in == ref_in);
         `MATCH_NAPOT: hit_out = ((addr_in & mask) == (ref_in & mask));
         `MATCH_GE:    hit_out = (addr_in >= ref_in);
         `MATCH_LT:    hit_out = (addr_in < ref_in);
         default:      hit_out = 1'b0;
      endcase
   end
endmodule // addr_match
`default_nettype wire

/* File: design/hart_trigger_breakpoint_csrs.sv */
// per-hart trigger select, trigger data bank and two breakpoints
// assumes the hart gives one csr access per cycle and the access under test
`include "trig_defs.svh"
`default_nettype none
module hart_trigger_breakpoint_csrs
   import trig_pkg::*;
#(
   parameter int XLEN      = 32,
   parameter int NUM_TRIG  = 2
) (
   input  wire logic            sys_clk_in,      // core clock
   input  wire logic            rst_in,          // sync reset, high
   input  wire logic            csr_valid_in,    // csr access this cycle
   input  wire logic            csr_write_in,    // access is a write
   input  wire logic [11:0]     csr_addr_in,     // csr number
   input  wire logic [XLEN-1:0] csr_wdata_in,    // write data
   input  wire logic [1:0]      priv_in,         // current privilege
   input  wire logic            debug_mode_in,   // hart in debug mode
   input  wire logic            debug_enter_in,  // pulse: entering debug
   input  wire logic            debug_exit_in,   // pulse: leaving debug
   input  wire logic [XLEN-1:0] pc_in,           // current pc
   input  wire logic [1:0]      acc_kind_in,     // access kind checked
   input  wire logic [XLEN-1:0] acc_addr_in,     // access address
   output logic [XLEN-1:0]      csr_rdata_out,   // read data
   output logic                 csr_illegal_out, // illegal instruction
   output logic                 bp_exc_out,      // breakpoint exception
   output logic                 bp_debug_out,    // breakpoint enters debug
   output logic                 resume_out,      // pulse: resume now
   output logic [XLEN-1:0]      resume_pc_out    // pc to resume at
);
   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   logic [XLEN-1:0] select_reg, select_next;
   logic [XLEN-1:0] ctrl_reg [NUM_TRIG];
   logic [XLEN-1:0] ctrl_next [NUM_TRIG];
   logic [XLEN-1:0] addr_reg [NUM_TRIG];
   logic [XLEN-1:0] addr_next [NUM_TRIG];
   logic [XLEN-1:0] dpc_reg, dpc_next;
   logic [XLEN-1:0] dcsr_reg, dcsr_next;
   logic [XLEN-1:0] dscratch_reg, dscratch_next;
   logic [XLEN-1:0] rdata_reg, rdata_next;
   logic            illegal_reg, illegal_next;
   logic            resume_reg, resume_next;

   logic            sel_ok;
   int unsigned     sel_idx;
   logic            is_trig_csr, is_dbg_csr, is_data_csr;
   logic            allowed, wr_ok;
   logic [NUM_TRIG-1:0] hit, qual, raw;

   // keep only bits that software may own; fixed fields forced
   function automatic logic [XLEN-1:0] legal_ctrl(
      input logic [XLEN-1:0] wr,
      input logic [XLEN-1:0] old,
      input logic            dbg);
      logic [XLEN-1:0] v;
      v = '0;
      v[`MC_MACHINE_BIT:`MC_LOAD_BIT] = wr[`MC_MACHINE_BIT:`MC_LOAD_BIT];
      // unsupported kinds keep the old kind so a readback shows it
      if (wr[`MC_MATCH_HI:`MC_MATCH_LO] <= `MATCH_LT)
         v[`MC_MATCH_HI:`MC_MATCH_LO] = wr[`MC_MATCH_HI:`MC_MATCH_LO];
      else
         v[`MC_MATCH_HI:`MC_MATCH_LO] = old[`MC_MATCH_HI:`MC_MATCH_LO];
      v[`MC_CHAIN_BIT] = wr[`MC_CHAIN_BIT];
      if (wr[`MC_ACTION_HI:`MC_ACTION_LO] <= `ACTION_DEBUG)
         v[`MC_ACTION_HI:`MC_ACTION_LO] = wr[`MC_ACTION_HI:`MC_ACTION_LO];
      else
         v[`MC_ACTION_HI:`MC_ACTION_LO] = old[`MC_ACTION_HI:`MC_ACTION_LO];
      v[`MC_TIMING_BIT] = 1'b0;
      v[`MC_SELECT_BIT] = 1'b0;
      v[`MC_MASKMAX_HI:`MC_MASKMAX_LO] = `MASKMAX_VALUE;
      // only debug mode code may claim the debug-only view
      v[`MC_DMODE_BIT] = dbg ? wr[`MC_DMODE_BIT] : 1'b0;
      v[`MC_TYPE_HI:`MC_TYPE_LO] = `TYPE_ADDR_MATCH;
      return v;
   endfunction

   // -------------------------------------------------------------
   // access decode
   // -------------------------------------------------------------
   always_comb begin
      sel_ok   = (select_reg < XLEN'(NUM_TRIG));
      sel_idx  = sel_ok ? int'(select_reg) : 0;
      is_trig_csr = (csr_addr_in == `CSR_TRIGGER_SELECT) ||
                    (csr_addr_in == `CSR_TRIGGER_FIRST)  ||
                    (csr_addr_in == `CSR_TRIGGER_SECOND) ||
                    (csr_addr_in == `CSR_TRIGGER_THIRD);
      is_data_csr = is_trig_csr && (csr_addr_in != `CSR_TRIGGER_SELECT);
      is_dbg_csr  = (csr_addr_in == `CSR_DEBUG_CONTROL) ||
                    (csr_addr_in == `CSR_DEBUG_PC)      ||
                    (csr_addr_in == `CSR_DEBUG_SCRATCH);
      allowed = 1'b0;
      if (is_trig_csr)
         allowed = debug_mode_in || (priv_in == PRIV_MACHINE);
      if (is_dbg_csr)
         allowed = debug_mode_in;
      if (is_data_csr && sel_ok && !debug_mode_in &&
          ctrl_reg[sel_idx][`MC_DMODE_BIT])
         allowed = 1'b0;
      wr_ok = csr_valid_in && csr_write_in && allowed;
   end

   // -------------------------------------------------------------
   // read data and refusal
   // -------------------------------------------------------------
   // idle and refused cycles read zero, so a refused read shows nothing
   // rdata and illegal stand one cycle; the next cycle replaces them
   always_comb begin
      illegal_next = csr_valid_in && !allowed;
      rdata_next   = '0;
      if (csr_valid_in && allowed) begin
         case (csr_addr_in)
            `CSR_TRIGGER_SELECT: rdata_next = select_reg;
            `CSR_TRIGGER_FIRST:  rdata_next = sel_ok ? ctrl_reg[sel_idx]
                                   : {`TYPE_NONE, {(XLEN-4){1'b0}}};
            `CSR_TRIGGER_SECOND: rdata_next = sel_ok ? addr_reg[sel_idx]
                                   : '0;
            `CSR_TRIGGER_THIRD:  rdata_next = '0;
            `CSR_DEBUG_CONTROL:  rdata_next = dcsr_reg;
            `CSR_DEBUG_PC:       rdata_next = dpc_reg;
            `CSR_DEBUG_SCRATCH:  rdata_next = dscratch_reg;
            default:             rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         rdata_reg   <= '0;
         illegal_reg <= 1'b0;
      end else begin
         rdata_reg   <= rdata_next;
         illegal_reg <= illegal_next;
      end
   end

   // -------------------------------------------------------------
   // trigger bank: select, control and address
   // -------------------------------------------------------------
   // writes land at the same edge that takes the access
   always_comb begin
      select_next = select_reg;
      for (int i = 0; i < NUM_TRIG; i++) begin
         ctrl_next[i] = ctrl_reg[i];
         addr_next[i] = addr_reg[i];
      end
      if (wr_ok) begin
         case (csr_addr_in)
            `CSR_TRIGGER_SELECT:
               // an index with no trigger is refused, old one kept
               if (csr_wdata_in < XLEN'(NUM_TRIG))
                  select_next = csr_wdata_in;
            `CSR_TRIGGER_FIRST:
               if (sel_ok)
                  ctrl_next[sel_idx] = legal_ctrl(csr_wdata_in,
                     ctrl_reg[sel_idx], debug_mode_in);
            `CSR_TRIGGER_SECOND:
               if (sel_ok)
                  addr_next[sel_idx] = csr_wdata_in;
            // the third register is reserved: its writes are dropped
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         select_reg <= `SELECT_RESET;
         // control comes up as type, maskmax and action zero only
         for (int i = 0; i < NUM_TRIG; i++) begin
            ctrl_reg[i] <= `CONTROL_RESET | {`TYPE_ADDR_MATCH, 1'b0,
               `MASKMAX_VALUE, {(XLEN-11){1'b0}}};
            addr_reg[i] <= '0;
         end
      end else begin
         select_reg <= select_next;
         for (int i = 0; i < NUM_TRIG; i++) begin
            ctrl_reg[i] <= ctrl_next[i];
            addr_reg[i] <= addr_next[i];
         end
      end
   end

   // -------------------------------------------------------------
   // debug registers and resume
   // -------------------------------------------------------------
   // dcsr is plain storage here; its fields belong to the hart
   always_comb begin
      dpc_next      = dpc_reg;
      dcsr_next     = dcsr_reg;
      dscratch_next = dscratch_reg;
      // resume follows the exit pulse by one cycle
      resume_next   = debug_exit_in;
      if (wr_ok) begin
         case (csr_addr_in)
            `CSR_DEBUG_CONTROL: dcsr_next = csr_wdata_in;
            `CSR_DEBUG_PC:      dpc_next = csr_wdata_in;
            `CSR_DEBUG_SCRATCH: dscratch_next = csr_wdata_in;
            default: ;
         endcase
      end
      // entry capture wins over a software write in the same cycle
      if (debug_enter_in)
         dpc_next = pc_in;
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         dpc_reg      <= '0;
         dcsr_reg     <= '0;
         dscratch_reg <= '0;
         resume_reg   <= 1'b0;
      end else begin
         dpc_reg      <= dpc_next;
         dcsr_reg     <= dcsr_next;
         dscratch_reg <= dscratch_next;
         resume_reg   <= resume_next;
      end
   end

   // -------------------------------------------------------------
   // breakpoint matching
   // -------------------------------------------------------------
   // one comparator per trigger; the kind comes straight from control
   for (genvar g = 0; g < NUM_TRIG; g++) begin : g_bp
      addr_match #(.XLEN(XLEN)) u_match (
         .kind_in (ctrl_reg[g][`MC_MATCH_HI:`MC_MATCH_LO]),
         .ref_in  (addr_reg[g]),
         .addr_in (acc_addr_in),
         .hit_out (hit[g])
      );
   end

   // debug mode code is never itself trapped
   always_comb begin
      for (int i = 0; i < NUM_TRIG; i++) begin
         case (acc_kind_in)
            ACC_LOAD:  qual[i] = ctrl_reg[i][`MC_LOAD_BIT];
            ACC_STORE: qual[i] = ctrl_reg[i][`MC_STORE_BIT];
            ACC_FETCH: qual[i] = ctrl_reg[i][`MC_FETCH_BIT];
            default:   qual[i] = 1'b0;
         endcase
         raw[i] = hit[i] && qual[i] && !debug_mode_in &&
                  ctrl_reg[i][`MC_USER_BIT + int'(priv_in)];
      end
   end

   // a chained trigger and its upper neighbour fire as one
   // the last trigger has no upper neighbour, so its chain bit is ignored
   always_comb begin
      logic fire;
      logic chained_below;
      fire          = 1'b0;
      chained_below = 1'b0;
      bp_exc_out    = 1'b0;
      bp_debug_out  = 1'b0;
      for (int i = 0; i < NUM_TRIG; i++) begin
         fire = raw[i];
         chained_below = (i > 0) &&
                         ctrl_reg[(i > 0) ? i-1 : 0][`MC_CHAIN_BIT];
         if (ctrl_reg[i][`MC_CHAIN_BIT])
            fire = (i < NUM_TRIG-1) ? 1'b0 : raw[i];
         if (chained_below)
            fire = raw[i] && raw[(i > 0) ? i-1 : 0];
         if (fire) begin
            if (ctrl_reg[i][`MC_ACTION_HI:`MC_ACTION_LO] == `ACTION_DEBUG)
               bp_debug_out = 1'b1;
            else
               bp_exc_out = 1'b1;
         end
      end
   end

   assign csr_rdata_out   = rdata_reg;
   assign csr_illegal_out = illegal_reg;
   assign resume_out      = resume_reg;
   assign resume_pc_out   = dpc_reg;
endmodule // hart_trigger_breakpoint_csrs
`default_nettype wire

/* File: tb/trig_checker_assertions.sv */
// assertions on the ports of the trigger csr unit
// assumes one clock and a synchronous active-high reset
`include "trig_defs.svh"
`default_nettype none
module trig_checker
   import trig_pkg::*;
#(
   parameter int XLEN     = 32,
   parameter int NUM_TRIG = 2
) (
   input wire logic            sys_clk_in,      // clock
   input wire logic            rst_in,          // reset
   input wire logic            csr_valid_in,    // access
   input wire logic            csr_write_in,    // write
   input wire logic [11:0]     csr_addr_in,     // csr number
   input wire logic [XLEN-1:0] csr_wdata_in,    // write data
   input wire logic [1:0]      priv_in,         // privilege
   input wire logic            debug_mode_in,   // debug mode
   input wire logic            debug_enter_in,  // entry pulse
   input wire logic            debug_exit_in,   // exit pulse
   input wire logic [XLEN-1:0] pc_in,           // pc
   input wire logic [1:0]      acc_kind_in,     // access kind
   input wire logic [XLEN-1:0] acc_addr_in,     // access address
   input wire logic [XLEN-1:0] csr_rdata_out,   // read data
   input wire logic            csr_illegal_out, // refused
   input wire logic            bp_exc_out,      // exception
   input wire logic            bp_debug_out,    // debug entry
   input wire logic            resume_out,      // resume
   input wire logic [XLEN-1:0] resume_pc_out    // resume pc
);
   // ------
   // checks
   // ------
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   logic trig_csr;
   logic dbg_csr;
   logic rd_dbg;
   assign trig_csr = (csr_addr_in[11:2] == 10'h1E8);
   assign dbg_csr  = (csr_addr_in inside {`CSR_DEBUG_CONTROL,
                      `CSR_DEBUG_PC, `CSR_DEBUG_SCRATCH});
   assign rd_dbg   = csr_valid_in && !csr_write_in && debug_mode_in;
   sequence enter_then_exit;
      debug_enter_in ##2 debug_exit_in;
   endsequence
   trig_refuse_a: assert property (
      csr_valid_in && trig_csr && !debug_mode_in && priv_in != 2'b11
      |=> csr_illegal_out && csr_rdata_out == '0)
      else $error("trigger csr access not refused");
   dbg_refuse_a: assert property (
      csr_valid_in && dbg_csr && !debug_mode_in |=> csr_illegal_out)
      else $error("debug csr access outside debug not refused");
   dbg_allow_a: assert property (
      csr_valid_in && dbg_csr && debug_mode_in |=> !csr_illegal_out)
      else $error("debug csr access refused in debug mode");
   select_legal_a: assert property (
      rd_dbg && csr_addr_in == `CSR_TRIGGER_SELECT
      |=> csr_rdata_out < NUM_TRIG)
      else $error("select holds an unimplemented index");
   fixed_fields_a: assert property (
      rd_dbg && csr_addr_in == `CSR_TRIGGER_FIRST
      |=> csr_rdata_out[31:28] == `TYPE_ADDR_MATCH
          && csr_rdata_out[19:18] == 2'b00)
      else $error("control fixed fields wrong");
   resume_pc_a: assert property (
      enter_then_exit |=> resume_out && resume_pc_out == $past(pc_in, 3))
      else $error("resume pc not the entry pc");
   no_resume_a: assert property (
      !debug_exit_in |=> !resume_out)
      else $error("resume without exit");
   quiet_fire_a: assert property (
      debug_mode_in || acc_kind_in == ACC_NONE
      |-> !bp_exc_out && !bp_debug_out)
      else $error("breakpoint fired without access");
endmodule // trig_checker

bind hart_trigger_breakpoint_csrs trig_checker #(.XLEN(XLEN),
   .NUM_TRIG(NUM_TRIG)) trig_checker_i (.sys_clk_in(sys_clk_in),
   .rst_in(rst_in), .csr_valid_in(csr_valid_in),
   .csr_write_in(csr_write_in), .csr_addr_in(csr_addr_in),
   .csr_wdata_in(csr_wdata_in), .priv_in(priv_in),
   .debug_mode_in(debug_mode_in), .debug_enter_in(debug_enter_in),
   .debug_exit_in(debug_exit_in), .pc_in(pc_in),
   .acc_kind_in(acc_kind_in), .acc_addr_in(acc_addr_in),
   .csr_rdata_out(csr_rdata_out), .csr_illegal_out(csr_illegal_out),
   .bp_exc_out(bp_exc_out), .bp_debug_out(bp_debug_out),
   .resume_out(resume_out), .resume_pc_out(resume_pc_out));
`default_nettype wire

/* File: tb/hart_model.sv */
// hart-side model: csr access path and privilege state
// assumes one clock; every change lands on the falling edge
`default_nettype none
module hart_model (
   input  wire logic        clk_in,     // core clock
   input  wire logic [31:0] rdata_in,   // csr read data
   input  wire logic        illegal_in, // refused access
   output logic             valid_out,  // access strobe
   output logic             write_out,  // write access
   output logic [11:0]      addr_out,   // csr number
   output logic [31:0]      wdata_out,  // write data
   output logic [1:0]       priv_out,   // privilege
   output logic             dbg_out     // debug mode
);
   timeunit 1ns;
   timeprecision 1ns;
   // -----
   // tasks
   // -----
   initial begin
      valid_out = 1'b0;
      write_out = 1'b0;
      addr_out  = 12'h000;
      wdata_out = 32'h0;
      priv_out  = 2'b11;
      dbg_out   = 1'b0;
   end
   task automatic mode(input logic [1:0] p, input logic d);
      @(negedge clk_in);
      priv_out = p;
      dbg_out  = d;
   endtask
   task automatic csr(input logic w, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] rd, output logic ill);
      @(negedge clk_in);
      valid_out = 1'b1;
      write_out = w;
      addr_out  = a;
      wdata_out = d;
      @(negedge clk_in);
      valid_out = 1'b0;
      // released lines flip so a stale value never helps the design
      addr_out  = ~a;
      wdata_out = ~d;
      rd        = rdata_in;
      ill       = illegal_in;
   endtask
endmodule // hart_model
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the trigger csr unit
// assumes design, checker and hart model are compiled before it
`include "trig_defs.svh"
`default_nettype none
module tb_top
   import trig_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ---------
   // scenarios
   // ---------
   localparam logic [31:0] CTRL_RST = {`TYPE_ADDR_MATCH, 1'b0,
                                      `MASKMAX_VALUE, 21'h0};
   logic        sys_clk_in, rst_in, valid, write, dbg, enter, leave;
   logic        ill, bp_exc, bp_dbg, resume;
   logic [11:0] addr;
   logic [1:0]  priv, kind;
   logic [31:0] wdata, pc, aaddr, rdata, resume_pc, rd;
   int          n_errors = 0, compares = 0, cycles = 0;
   hart_trigger_breakpoint_csrs hart_trigger_breakpoint_csrs_i (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .csr_valid_in(valid),
      .csr_write_in(write), .csr_addr_in(addr), .csr_wdata_in(wdata),
      .priv_in(priv), .debug_mode_in(dbg), .debug_enter_in(enter),
      .debug_exit_in(leave), .pc_in(pc), .acc_kind_in(kind),
      .acc_addr_in(aaddr), .csr_rdata_out(rdata),
      .csr_illegal_out(ill), .bp_exc_out(bp_exc),
      .bp_debug_out(bp_dbg), .resume_out(resume),
      .resume_pc_out(resume_pc));
   hart_model hart_model_i (.clk_in(sys_clk_in), .rdata_in(rdata),
      .illegal_in(ill), .valid_out(valid), .write_out(write),
      .addr_out(addr), .wdata_out(wdata), .priv_out(priv),
      .dbg_out(dbg));
   task automatic tally_and_finish();
      if (n_errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic i;
      hart_model_i.csr(1'b1, a, d, rd, i);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e,
         input logic ei);
      logic i;
      hart_model_i.csr(1'b0, a, 32'h0, rd, i);
      check(rd, e);
      check(32'(i), 32'(ei));
   endtask
   task automatic probe(input logic [1:0] k, input logic [31:0] a,
         input logic [1:0] p, input logic ee, input logic ed);
      hart_model_i.mode(p, 1'b0);
      kind  = k;
      aaddr = a;
      #1;
      check(32'(bp_exc), 32'(ee));
      check(32'(bp_dbg), 32'(ed));
   endtask
   task automatic t_regs();
      logic ig;
      rc(`CSR_TRIGGER_SELECT, 32'h0, 1'b0);
      rc(`CSR_TRIGGER_FIRST, CTRL_RST, 1'b0);
      rc(`CSR_TRIGGER_THIRD, 32'h0, 1'b0);
      hart_model_i.mode(2'b11, 1'b1);
      wr(`CSR_TRIGGER_SELECT, 32'h5);
      rc(`CSR_TRIGGER_SELECT, 32'h0, 1'b0);
      wr(`CSR_TRIGGER_SELECT, 32'h1);
      wr(`CSR_TRIGGER_SELECT, 32'h2);
      rc(`CSR_TRIGGER_SELECT, 32'h1, 1'b0);
      wr(`CSR_TRIGGER_SECOND, 32'hBBBB_0000);
      wr(`CSR_TRIGGER_SELECT, 32'h0);
      wr(`CSR_TRIGGER_SECOND, 32'hAAAA_0000);
      wr(`CSR_TRIGGER_THIRD, 32'hFFFF);
      rc(`CSR_TRIGGER_SECOND, 32'hAAAA_0000, 1'b0);
      rc(`CSR_TRIGGER_THIRD, 32'h0, 1'b0);
      wr(`CSR_TRIGGER_SELECT, 32'h1);
      rc(`CSR_TRIGGER_SECOND, 32'hBBBB_0000, 1'b0);
      wr(`CSR_TRIGGER_SELECT, 32'h0);
      hart_model_i.mode(2'b11, 1'b0);
      wr(`CSR_TRIGGER_FIRST, 32'hFFFF_FFFF);
      rc(`CSR_TRIGGER_SELECT, 32'h0, 1'b0);
      hart_model_i.csr(1'b0, `CSR_TRIGGER_FIRST, 32'h0, rd, ig);
      check(rd & 32'hFFEF_FFFF, CTRL_RST | 32'h087F);
      check(rd & 32'h000C_0000, 32'h0);
      check(32'(ig), 32'h0);
      wr(`CSR_TRIGGER_FIRST, 32'h1100);
      rc(`CSR_TRIGGER_FIRST, CTRL_RST | 32'h1100, 1'b0);
      wr(`CSR_TRIGGER_FIRST, 32'h2280);
      rc(`CSR_TRIGGER_FIRST, CTRL_RST | 32'h1100, 1'b0);
   endtask
   task automatic t_access();
      for (int p = 0; p < 3; p++) begin
         hart_model_i.mode(2'(p), 1'b0);
         wr(`CSR_TRIGGER_SELECT, 32'h1);
         rc(`CSR_TRIGGER_FIRST, 32'h0, 1'b1);
         rc(`CSR_DEBUG_PC, 32'h0, 1'b1);
      end
      hart_model_i.mode(2'b11, 1'b0);
      rc(`CSR_TRIGGER_SELECT, 32'h0, 1'b0);
      rc(`CSR_DEBUG_SCRATCH, 32'h0, 1'b1);
      hart_model_i.mode(2'b11, 1'b1);
      wr(`CSR_DEBUG_SCRATCH, 32'h5A5A_A5A5);
      rc(`CSR_DEBUG_SCRATCH, 32'h5A5A_A5A5, 1'b0);
      wr(`CSR_TRIGGER_FIRST, 32'h0800_0000);
      hart_model_i.mode(2'b11, 1'b0);
      rc(`CSR_TRIGGER_FIRST, 32'h0, 1'b1);
      rc(`CSR_TRIGGER_SECOND, 32'h0, 1'b1);
      hart_model_i.mode(2'b11, 1'b1);
      rc(`CSR_TRIGGER_FIRST, CTRL_RST | 32'h0800_0000, 1'b0);
      wr(`CSR_TRIGGER_FIRST, 32'h0);
   endtask
   task automatic t_resume();
      @(negedge sys_clk_in);
      enter = 1'b1;
      pc    = 32'h1234_5678;
      @(negedge sys_clk_in);
      enter = 1'b0;
      pc    = 32'h0000_0100;
      hart_model_i.mode(2'b11, 1'b1);
      leave = 1'b1;
      @(negedge sys_clk_in);
      leave = 1'b0;
      check(32'(resume), 32'h1);
      check(resume_pc, 32'h1234_5678);
      rc(`CSR_DEBUG_PC, 32'h1234_5678, 1'b0);
   endtask
   task automatic t_fire();
      hart_model_i.mode(2'b11, 1'b0);
      wr(`CSR_TRIGGER_SECOND, 32'h4000);
      wr(`CSR_TRIGGER_FIRST, 32'h0044);
      probe(ACC_FETCH, 32'h4000, 2'b11, 1'b1, 1'b0);
      probe(ACC_LOAD, 32'h4000, 2'b11, 1'b0, 1'b0);
      probe(ACC_FETCH, 32'h4000, 2'b00, 1'b0, 1'b0);
      probe(ACC_FETCH, 32'h4004, 2'b11, 1'b0, 1'b0);
      wr(`CSR_TRIGGER_FIRST, 32'h1044);
      probe(ACC_FETCH, 32'h4000, 2'b11, 1'b0, 1'b1);
      wr(`CSR_TRIGGER_SECOND, 32'h0100);
      wr(`CSR_TRIGGER_FIRST, 32'h0941);
      wr(`CSR_TRIGGER_SELECT, 32'h1);
      wr(`CSR_TRIGGER_SECOND, 32'h0200);
      wr(`CSR_TRIGGER_FIRST, 32'h01C1);
      probe(ACC_LOAD, 32'h0150, 2'b11, 1'b1, 1'b0);
      probe(ACC_LOAD, 32'h0250, 2'b11, 1'b0, 1'b0);
      probe(ACC_LOAD, 32'h0050, 2'b11, 1'b0, 1'b0);
      wr(`CSR_TRIGGER_SELECT, 32'h0);
      wr(`CSR_TRIGGER_SECOND, 32'h0000_4007);
      wr(`CSR_TRIGGER_FIRST, 32'h00C1);
      probe(ACC_LOAD, 32'h0000_400C, 2'b11, 1'b1, 1'b0);
      probe(ACC_LOAD, 32'h0000_4010, 2'b11, 1'b0, 1'b0);
      kind = ACC_NONE;
   endtask
   always #25 sys_clk_in = ~sys_clk_in;
   // limit well above the roughly 150 cycles the scenarios need
   always @(posedge sys_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial begin
      sys_clk_in = 1'b0;
      rst_in     = 1'b1;
      enter      = 1'b0;
      leave      = 1'b0;
      pc         = 32'h0;
      kind       = ACC_NONE;
      aaddr      = 32'h0;
      repeat (12) @(negedge sys_clk_in);
      rst_in = 1'b0;
      t_regs();
      t_access();
      t_resume();
      t_fire();
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
